// File: design/scm_pkg.sv
// package: constants, layouts and types of the host bus port
`default_nettype none
package scm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // window offsets relative to the peripheral base, in bytes
    localparam logic [15:0] WIN_LO_OFF     = 16'h0200;   // 512
    localparam logic [15:0] WIN_HI_OFF     = 16'h037f;   // 895
    localparam logic [15:0] TX_DMA16_OFF   = 16'h0200;   // 512
    localparam logic [15:0] TX_DMA8_OFF    = 16'h0240;   // 576
    localparam logic [15:0] RX_DMA16_OFF   = 16'h0280;   // 640
    localparam logic [15:0] RX_DMA8_OFF    = 16'h02c0;   // 704
    localparam logic [15:0] SER_LO_OFF     = 16'h0300;   // 768
    localparam logic [15:0] SER_HI_OFF     = 16'h0340;   // 832
    localparam logic [15:0] BASE_DEFAULT   = 16'h0000;

    // address bit positions inside the window offset
    localparam int          CD_SEL_BIT     = 7;          // command/data select
    localparam int          SPACE_SEL_BIT  = 8;          // space select
    localparam int          BYTE_REG_BIT   = 6;          // 8-bit region inside dma space

    // memory geometry
    localparam int          MEM_AW         = 7;
    localparam int          MEM_DW         = 16;
    localparam int          MEM_DEPTH      = 128;

    // register indexes inside the serial command region (word index)
    localparam logic [4:0]  MODEM_IDX      = 5'h00;
    localparam logic [4:0]  STATUS_IDX     = 5'h01;

    // bus setup word fields and reset
    localparam int          CFG_NOADDR_BIT = 15;
    localparam int          CFG_DMA_HI     = 7;
    localparam int          CFG_DMA_LO     = 6;
    localparam int          CFG_IACK_HI    = 5;
    localparam int          CFG_IACK_LO    = 4;
    localparam int          CFG_BREQ_BIT   = 3;
    localparam int          CFG_WIDE_BIT   = 2;
    localparam int          CFG_IRQ_BIT    = 1;
    localparam int          CFG_SHR_BIT    = 0;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    localparam logic [15:0] CFG_RECOMMEND  = 16'h00f7;
    localparam logic [1:0]  DMA_SWAP_MODE  = 2'h3;
    localparam logic [1:0]  IACK_DOUBLE    = 2'h3;

    // read pipeline length in cycles, memory latency plus output register
    localparam logic [1:0]  RD_LAT         = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        no_sep_addr;
        logic [6:0]  must_zero;
        logic [1:0]  dma_lane;
        logic [1:0]  iack_mode;
        logic        breq_push;
        logic        wide_bus;
        logic        irq_od;
        logic        shift_right;
    } scm_cfg_t;

    typedef struct packed {
        logic              we;
        logic [1:0]        be;
        logic [MEM_AW-1:0] addr;
        logic [MEM_DW-1:0] wdata;
    } scm_mem_req_t;

    typedef enum logic [1:0] {
        SCM_IDLE  = 2'b00,
        SCM_READ  = 2'b01,
        SCM_DRIVE = 2'b10
    } scm_rd_state_t;

endpackage
`default_nettype wire

// File: design/scm_regmem.sv
// register storage of the dma and serial regions with byte enables
`default_nettype none
module scm_regmem (
    input  wire logic                        clk_i,
    input  wire scm_pkg::scm_mem_req_t       req_i,
    input  wire logic                        req_vld_i,
    output logic [scm_pkg::MEM_DW-1:0]       rdata_o
);
    logic [scm_pkg::MEM_DW-1:0] mem [scm_pkg::MEM_DEPTH];
    logic [scm_pkg::MEM_DW-1:0] rdata_r;

    always_ff @(posedge clk_i) begin
        if (req_vld_i && req_i.we && req_i.be[0]) begin
            mem[req_i.addr][7:0] <= req_i.wdata[7:0];
        end
        if (req_vld_i && req_i.we && req_i.be[1]) begin
            mem[req_i.addr][15:8] <= req_i.wdata[15:8];
        end
        rdata_r <= mem[req_i.addr];
    end

    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// File: design/scm_iack.sv
// interrupt acknowledge pulse counter, single or double pulsed
`default_nettype none
module scm_iack (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       ack_n_i,
    output logic            answer_o
);
    logic ack_n_r;
    logic ack_n_nxt;
    logic second_r;
    logic second_nxt;
    logic answer_r;
    logic answer_nxt;

    always_comb begin
        ack_n_nxt  = ack_n_i;
        second_nxt = second_r;
        answer_nxt = answer_r;
        if (ack_n_r && !ack_n_i) begin
            if (mode_i == scm_pkg::IACK_DOUBLE) begin
                // first pulse only arms, the vector goes out on the second
                second_nxt = !second_r;
                answer_nxt = second_r;
            end else begin
                second_nxt = 1'b0;
                answer_nxt = 1'b1;
            end
        end else if (ack_n_i) begin
            answer_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_n_r  <= 1'b1;
            second_r <= 1'b0;
            answer_r <= 1'b0;
        end else begin
            ack_n_r  <= ack_n_nxt;
            second_r <= second_nxt;
            answer_r <= answer_nxt;
        end
    end

    assign answer_o = answer_r;
endmodule
`default_nettype wire

// File: design/scm_host_port.sv
// host bus slave port of the serial controller with internal dma
//
// Function
// - first write in the window after reset loads the bus setup word.
// - command/data select follows A7, space select follows A8.
// - space select high at setup write picks wait style on wait/ready pin.
// - setup bit 15 one means no separate address on upper pins.
// - setup bits 7:6 at 11 give word or lane-alternating byte dma.
// - setup bits 5:4 at 11 give double-pulsed acknowledge handling.
// - address strobe activity switches the port to multiplexed operation.
// - access width comes from the address region, 16-bit or either byte lane.
// - window spans base+512 to base+895.
// - base+512..575 word, base+576..639 byte access to transmit dma registers.
// - base+640..703 word, base+704..767 byte access to receive dma registers.
// - base+768..895 maps serial controller registers, word access only.
// - bus clock never feeds the baud generators; bit clocks come on own pins.
// - transfer request pins act as modem outputs, undriven after reset.
`default_nettype none
module scm_host_port #(
    parameter logic [15:0] PERIPH_BASE = scm_pkg::BASE_DEFAULT
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic [15:0] AD_I,
    output logic      [15:0] AD_O,
    output logic             AD_OE_O,
    input  wire logic        ADDRESS_STROBE_N_I,
    input  wire logic        DEV_SEL_N_I,
    input  wire logic        RD_N_I,
    input  wire logic        WR_N_I,
    output logic             WAIT_RDY_O,
    input  wire logic        IRQ_ACKNOWLEDGE_INPUT_N_I,
    output logic             IACK_ANSWER_O,
    input  wire logic        IRQ_PEND_I,
    output logic             IRQ_N_O,
    output logic             IRQ_N_OE_O,
    input  wire logic        BUS_NEED_I,
    output logic             BUS_OWNERSHIP_REQUEST_N_O,
    output logic             BUS_OWNERSHIP_REQUEST_N_OE_O,
    output logic             TRANSMIT_TRANSFER_REQUEST_N_O,
    output logic             TRANSMIT_TRANSFER_REQUEST_N_OE_O,
    output logic             RECEIVE_TRANSFER_REQUEST_N_O,
    output logic             RECEIVE_TRANSFER_REQUEST_N_OE_O,
    output logic [1:0]       DMA_LANE_MODE_O,
    output logic             NO_SEP_ADDR_O,
    output logic             WIDE_BUS_O,
    output logic             MUX_MODE_O,
    output logic             SETUP_DONE_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [15:0] win_offset(input logic [15:0] a);
        win_offset = a - PERIPH_BASE;
    endfunction

    function automatic logic in_window(input logic [15:0] off);
        in_window = (off >= scm_pkg::WIN_LO_OFF) && (off <= scm_pkg::WIN_HI_OFF);
    endfunction

    // 8-bit access only in the upper half of each dma region
    function automatic logic byte_region(input logic [15:0] off);
        byte_region = !off[scm_pkg::SPACE_SEL_BIT] && off[scm_pkg::BYTE_REG_BIT];
    endfunction

    // word index and byte lane of the register, per address shift mode
    function automatic logic [5:0] reg_word(input logic [15:0] off, input logic shr);
        if (shr) begin
            reg_word = {off[0], off[5:1]};
        end else begin
            reg_word = {off[1], off[6:2]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic                       as_n_r, as_n_nxt;
    logic                       wr_n_r, wr_n_nxt;
    logic                       rd_n_r, rd_n_nxt;
    logic [15:0]                addr_r, addr_nxt;
    logic                       mux_r, mux_nxt;
    scm_pkg::scm_cfg_t          cfg_r, cfg_nxt;
    logic                       done_r, done_nxt;
    logic                       wstyle_r, wstyle_nxt;
    scm_pkg::scm_rd_state_t     rst_r, rst_nxt;
    logic                       stat_sel_r, stat_sel_nxt;
    logic [15:0]                ad_o_r, ad_o_nxt;
    logic                       ad_oe_r, ad_oe_nxt;
    logic                       wrdy_r, wrdy_nxt;
    logic                       irq_r, irq_nxt;
    logic                       irq_oe_r, irq_oe_nxt;
    logic                       breq_r, breq_nxt;
    logic                       breq_oe_r, breq_oe_nxt;
    logic [3:0]                 modem_r, modem_nxt;
    scm_pkg::scm_mem_req_t      mreq;
    logic                       mreq_vld;
    logic [15:0]                mem_rdata;
    logic                       iack_ans;
    logic                       iack_r;

    logic [15:0]                off;
    logic [5:0]                 wsel;
    logic                       cycle_ok;

    scm_regmem u_regmem (
        .clk_i     (CLK_SYS_I),
        .req_i     (mreq),
        .req_vld_i (mreq_vld),
        .rdata_o   (mem_rdata)
    );

    scm_iack u_iack (
        .clk_i    (CLK_SYS_I),
        .rst_n_i  (RST_N_I),
        .mode_i   (cfg_r.iack_mode),
        .ack_n_i  (IRQ_ACKNOWLEDGE_INPUT_N_I),
        .answer_o (iack_ans)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        off          = win_offset(addr_r);
        wsel         = reg_word(off, cfg_r.shift_right);
        cycle_ok     = !DEV_SEL_N_I && in_window(off);
        as_n_nxt     = ADDRESS_STROBE_N_I;
        wr_n_nxt     = WR_N_I;
        rd_n_nxt     = RD_N_I;
        addr_nxt     = addr_r;
        mux_nxt      = mux_r;
        cfg_nxt      = cfg_r;
        done_nxt     = done_r;
        wstyle_nxt   = wstyle_r;
        rst_nxt      = rst_r;
        stat_sel_nxt = stat_sel_r;
        ad_o_nxt     = ad_o_r;
        ad_oe_nxt    = ad_oe_r;
        modem_nxt    = modem_r;
        mreq_vld     = 1'b0;
        // A8 picks serial/dma space, A7 command/data, then the word inside
        mreq.addr    = {off[scm_pkg::SPACE_SEL_BIT], off[scm_pkg::CD_SEL_BIT], wsel[4:0]};
        mreq.we      = 1'b0;
        mreq.be      = 2'b11;
        mreq.wdata   = AD_I;

        // address phase: latch while the strobe is low
        if (!ADDRESS_STROBE_N_I) begin
            addr_nxt = AD_I;
        end
        if (as_n_r != ADDRESS_STROBE_N_I) begin
            mux_nxt = 1'b1;
        end

        // write taken on the falling edge of the write strobe
        if (wr_n_r && !WR_N_I && cycle_ok) begin
            if (!done_r) begin
                cfg_nxt    = scm_pkg::scm_cfg_t'(AD_I);
                done_nxt   = 1'b1;
                wstyle_nxt = off[scm_pkg::SPACE_SEL_BIT];
            end else begin
                mreq_vld = 1'b1;
                mreq.we  = 1'b1;
                if (byte_region(off)) begin
                    // even byte on low lane, odd byte on high lane
                    mreq.be    = wsel[5] ? 2'b10 : 2'b01;
                    if (!cfg_r.wide_bus) begin
                        mreq.wdata = {AD_I[7:0], AD_I[7:0]};
                    end
                end
                if (off[scm_pkg::SPACE_SEL_BIT] && !off[scm_pkg::CD_SEL_BIT]
                    && wsel[4:0] == scm_pkg::MODEM_IDX) begin
                    modem_nxt = AD_I[3:0];
                end
            end
        end

        // read: address the memory, then drive the registered word
        case (rst_r)
            scm_pkg::SCM_IDLE: begin
                ad_oe_nxt = 1'b0;
                if (rd_n_r && !RD_N_I && cycle_ok && done_r) begin
                    mreq_vld     = 1'b1;
                    stat_sel_nxt = off[scm_pkg::SPACE_SEL_BIT] && !off[scm_pkg::CD_SEL_BIT]
                                   && wsel[4:0] == scm_pkg::STATUS_IDX;
                    rst_nxt      = scm_pkg::SCM_READ;
                end
            end
            scm_pkg::SCM_READ: begin
                ad_o_nxt  = stat_sel_r ? {mux_r, done_r, wstyle_r, 5'h00, cfg_r[7:0]} : mem_rdata;
                ad_oe_nxt = !RD_N_I;
                rst_nxt   = RD_N_I ? scm_pkg::SCM_IDLE : scm_pkg::SCM_DRIVE;
            end
            scm_pkg::SCM_DRIVE: begin
                ad_oe_nxt = !RD_N_I;
                if (RD_N_I) begin
                    rst_nxt = scm_pkg::SCM_IDLE;
                end
            end
            default: begin
                rst_nxt = scm_pkg::SCM_IDLE;
            end
        endcase

        // wait style holds the cycle low while data is fetched, ready style the reverse
        if (wstyle_r) begin
            wrdy_nxt = !(rst_nxt == scm_pkg::SCM_READ);
        end else begin
            wrdy_nxt = (rst_nxt == scm_pkg::SCM_DRIVE);
        end

        // open-drain pins pull low only, push-pull pins always driven
        if (cfg_r.irq_od) begin
            irq_nxt    = 1'b0;
            irq_oe_nxt = IRQ_PEND_I;
        end else begin
            irq_nxt    = !IRQ_PEND_I;
            irq_oe_nxt = 1'b1;
        end
        if (!cfg_r.breq_push) begin
            breq_nxt    = 1'b0;
            breq_oe_nxt = BUS_NEED_I;
        end else begin
            breq_nxt    = !BUS_NEED_I;
            breq_oe_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            as_n_r     <= 1'b1;
            wr_n_r     <= 1'b1;
            rd_n_r     <= 1'b1;
            addr_r     <= 16'h0000;
            mux_r      <= 1'b0;
            cfg_r      <= scm_pkg::scm_cfg_t'(scm_pkg::CFG_RESET);
            done_r     <= 1'b0;
            wstyle_r   <= 1'b0;
            rst_r      <= scm_pkg::SCM_IDLE;
            stat_sel_r <= 1'b0;
            ad_o_r     <= 16'h0000;
            ad_oe_r    <= 1'b0;
            wrdy_r     <= 1'b1;
            irq_r      <= 1'b0;
            irq_oe_r   <= 1'b0;
            breq_r     <= 1'b0;
            breq_oe_r  <= 1'b0;
            modem_r    <= 4'h0;
            iack_r     <= 1'b0;
        end else begin
            as_n_r     <= as_n_nxt;
            wr_n_r     <= wr_n_nxt;
            rd_n_r     <= rd_n_nxt;
            addr_r     <= addr_nxt;
            mux_r      <= mux_nxt;
            cfg_r      <= cfg_nxt;
            done_r     <= done_nxt;
            wstyle_r   <= wstyle_nxt;
            rst_r      <= rst_nxt;
            stat_sel_r <= stat_sel_nxt;
            ad_o_r     <= ad_o_nxt;
            ad_oe_r    <= ad_oe_nxt;
            wrdy_r     <= wrdy_nxt;
            irq_r      <= irq_nxt;
            irq_oe_r   <= irq_oe_nxt;
            breq_r     <= breq_nxt;
            breq_oe_r  <= breq_oe_nxt;
            modem_r    <= modem_nxt;
            iack_r     <= iack_ans;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; bit clocks for the baud generators arrive on the serial clock pins,
    // this port's clock is never offered to them

    assign AD_O                             = ad_o_r;
    assign AD_OE_O                          = ad_oe_r;
    assign WAIT_RDY_O                       = wrdy_r;
    assign IACK_ANSWER_O                    = iack_r;
    assign IRQ_N_O                          = irq_r;
    assign IRQ_N_OE_O                       = irq_oe_r;
    assign BUS_OWNERSHIP_REQUEST_N_O        = breq_r;
    assign BUS_OWNERSHIP_REQUEST_N_OE_O     = breq_oe_r;
    assign TRANSMIT_TRANSFER_REQUEST_N_O    = modem_r[1];
    assign TRANSMIT_TRANSFER_REQUEST_N_OE_O = modem_r[0];
    assign RECEIVE_TRANSFER_REQUEST_N_O     = modem_r[3];
    assign RECEIVE_TRANSFER_REQUEST_N_OE_O  = modem_r[2];
    assign DMA_LANE_MODE_O                  = cfg_r.dma_lane;
    assign NO_SEP_ADDR_O                    = cfg_r.no_sep_addr;
    assign WIDE_BUS_O                       = cfg_r.wide_bus;
    assign MUX_MODE_O                       = mux_r;
    assign SETUP_DONE_O                     = done_r;

endmodule
`default_nettype wire

// File: verif/scm_host_model.sv
// host processor model driving multiplexed address/data bus cycles
`default_nettype none
module scm_host_model #(
    parameter logic [15:0] BASE = 16'h0000
) (
    input  wire logic        clk_i,
    input  wire logic [15:0] ad_i,
    input  wire logic        ad_oe_i,
    output logic      [15:0] ad_o,
    output logic             as_n_o,
    output logic             sel_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ad_o = 16'h0000;
        as_n_o = 1'b1;
        sel_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    // one bus cycle; a read holds its strobe until the answer is sampled or 6 cycles pass
    task automatic cyc(input logic [15:0] off, input logic we, input logic [15:0] wd);
        int n;
        @(posedge clk_i);
        as_n_o <= 1'b0;
        ad_o <= BASE + off;
        @(posedge clk_i);
        as_n_o <= 1'b1;
        ad_o <= ~(BASE + off);
        @(posedge clk_i);
        sel_n_o <= !(off >= scm_pkg::WIN_LO_OFF && off <= scm_pkg::WIN_HI_OFF);
        wr_n_o <= !we;
        rd_n_o <= we;
        if (we) ad_o <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!we && ad_oe_i !== 1'b1 && n < 6);
        sel_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        // released lines never keep the last value
        ad_o <= ~ad_i;
        repeat (2) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: verif/scm_host_port_monitor.sv
// concurrent checks on the host port pins
`default_nettype none
module scm_host_port_monitor #(
    parameter logic [15:0] PERIPH_BASE = 16'h0000
) (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_N_I,
    input wire logic [15:0] AD_I,
    input wire logic        AD_OE_O,
    input wire logic        WAIT_RDY_O,
    input wire logic        ADDRESS_STROBE_N_I,
    input wire logic        DEV_SEL_N_I,
    input wire logic        RD_N_I,
    input wire logic        WR_N_I,
    input wire logic        IRQ_ACKNOWLEDGE_INPUT_N_I,
    input wire logic        IACK_ANSWER_O,
    input wire logic        IRQ_PEND_I,
    input wire logic        IRQ_N_O,
    input wire logic        IRQ_N_OE_O,
    input wire logic        BUS_NEED_I,
    input wire logic        BUS_OWNERSHIP_REQUEST_N_O,
    input wire logic        BUS_OWNERSHIP_REQUEST_N_OE_O,
    input wire logic        TRANSMIT_TRANSFER_REQUEST_N_OE_O,
    input wire logic        RECEIVE_TRANSFER_REQUEST_N_OE_O,
    input wire logic [1:0]  DMA_LANE_MODE_O,
    input wire logic        NO_SEP_ADDR_O,
    input wire logic        WIDE_BUS_O,
    input wire logic        MUX_MODE_O,
    input wire logic        SETUP_DONE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] addr_r;
    logic [15:0] cfg_r;
    logic        rd_q;
    logic        wr_q;
    logic [15:0] off;
    logic        in_win;
    logic        rd_take;
    logic        wr_take;
    logic        wstyle_q;
    assign off = addr_r - PERIPH_BASE;
    assign in_win = off >= scm_pkg::WIN_LO_OFF && off <= scm_pkg::WIN_HI_OFF;
    assign rd_take = !RD_N_I && rd_q && !DEV_SEL_N_I && in_win;
    assign wr_take = !WR_N_I && wr_q && !DEV_SEL_N_I && in_win;
    always_ff @(posedge CLK_SYS_I) begin
        rd_q <= RD_N_I;
        wr_q <= WR_N_I;
        if (!ADDRESS_STROBE_N_I) addr_r <= AD_I;
        if (!RST_N_I) cfg_r <= 16'h0000;
        else if (wr_take && !SETUP_DONE_O) cfg_r <= AD_I;
        if (wr_take && !SETUP_DONE_O) wstyle_q <= off[scm_pkg::SPACE_SEL_BIT];
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (rd_take && SETUP_DONE_O |-> ##[1:3] AD_OE_O)
        else $error("read in window not answered");
    a_oe_release: assert property (RD_N_I [*3] |-> !AD_OE_O)
        else $error("data lines driven without read");
    a_no_early_oe: assert property (!SETUP_DONE_O [*4] |-> !AD_OE_O)
        else $error("read answered before setup word");
    a_setup_load: assert property (wr_take && !SETUP_DONE_O |-> ##[1:2] SETUP_DONE_O)
        else $error("first write did not load setup word");
    a_cfg_fields: assert property (SETUP_DONE_O && $past(SETUP_DONE_O) |-> DMA_LANE_MODE_O == cfg_r[7:6]
        && NO_SEP_ADDR_O == cfg_r[15] && WIDE_BUS_O == cfg_r[2])
        else $error("setup fields differ from written word");
    a_irq_drain: assert property ($past(SETUP_DONE_O, 2) && cfg_r[1] |-> !IRQ_N_O
        && IRQ_N_OE_O == $past(IRQ_PEND_I))
        else $error("interrupt pin not open drain");
    a_breq_drain: assert property ($past(RST_N_I) && !cfg_r[3] |-> !BUS_OWNERSHIP_REQUEST_N_O
        && BUS_OWNERSHIP_REQUEST_N_OE_O == $past(BUS_NEED_I))
        else $error("bus request pin not open drain");
    a_mux_set: assert property ($fell(ADDRESS_STROBE_N_I) |-> ##[1:2] MUX_MODE_O)
        else $error("strobe activity did not set mux mode");
    a_modem_idle: assert property (!SETUP_DONE_O |-> !TRANSMIT_TRANSFER_REQUEST_N_OE_O
        && !RECEIVE_TRANSFER_REQUEST_N_OE_O)
        else $error("modem outputs driven after reset");
    // the answer lags the input by two registers
    a_iack_drop: assert property (IRQ_ACKNOWLEDGE_INPUT_N_I [*3] |-> !IACK_ANSWER_O)
        else $error("acknowledge answer held after input high");
    a_wait_pulse: assert property (rd_take && SETUP_DONE_O && wstyle_q |=> !WAIT_RDY_O ##1 WAIT_RDY_O)
        else $error("wait style read not extended by one cycle");
endmodule
bind scm_host_port scm_host_port_monitor #(.PERIPH_BASE(PERIPH_BASE)) u_mon (.*);
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench of the host bus port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, as_n, sel_n, rd_n, wr_n, iack_n, pend, need, oe_q;
    logic        ad_oe, wait_rdy, ans, irq_n, irq_oe, br_n, br_oe, tx_n, tx_oe, rx_n, rx_oe;
    logic        nosep, wide, mux, done;
    logic [1:0]  lane;
    logic [15:0] host_ad, ad_bus, ad_o, w, b, exp_v;
    logic [15:0] exp_q [$];
    logic [15:0] offs [4] = '{16'h0204, 16'h0284, 16'h0304, 16'h0346};
    logic [31:0] seed = 32'h8f3e3e62;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc_cnt = 0;
    assign ad_bus = ad_oe ? ad_o : host_ad;
    scm_host_model i_host (.clk_i(clk), .ad_i(ad_bus), .ad_oe_i(ad_oe), .ad_o(host_ad), .as_n_o(as_n),
        .sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n));
    scm_host_port i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .AD_I(ad_bus), .AD_O(ad_o), .AD_OE_O(ad_oe),
        .ADDRESS_STROBE_N_I(as_n), .DEV_SEL_N_I(sel_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
        .WAIT_RDY_O(wait_rdy), .IRQ_ACKNOWLEDGE_INPUT_N_I(iack_n), .IACK_ANSWER_O(ans),
        .IRQ_PEND_I(pend), .IRQ_N_O(irq_n), .IRQ_N_OE_O(irq_oe), .BUS_NEED_I(need),
        .BUS_OWNERSHIP_REQUEST_N_O(br_n), .BUS_OWNERSHIP_REQUEST_N_OE_O(br_oe),
        .TRANSMIT_TRANSFER_REQUEST_N_O(tx_n), .TRANSMIT_TRANSFER_REQUEST_N_OE_O(tx_oe),
        .RECEIVE_TRANSFER_REQUEST_N_O(rx_n), .RECEIVE_TRANSFER_REQUEST_N_OE_O(rx_oe),
        .DMA_LANE_MODE_O(lane), .NO_SEP_ADDR_O(nosep), .WIDE_BUS_O(wide), .MUX_MODE_O(mux),
        .SETUP_DONE_O(done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        compares++;
        if (got !== e) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd(input logic [15:0] off, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.cyc(off, 1'b0, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // answer watcher: every new answer takes the oldest expectation
    always @(posedge clk) begin
        oe_q <= ad_oe;
        if (ad_oe && !oe_q) begin
            exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : ~ad_o;
            chk(ad_o, exp_v);
        end
    end
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        iack_n = 1'b1;
        pend = 1'b0;
        need = 1'b0;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({tx_oe, rx_oe, done}, 16'h0000);
        i_host.cyc(16'h0302, 1'b0, 16'h0000);
        i_host.cyc(16'h0300, 1'b1, scm_pkg::CFG_RECOMMEND);
        @(negedge clk);
        chk({done, mux, nosep, wide, lane}, 16'h0037);
        rd(16'h0302, 16'he0f7);
        i_host.cyc(16'h0380, 1'b0, 16'h0000);
        i_host.cyc(16'h01fe, 1'b0, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            w = rnd();
            i_host.cyc(offs[i], 1'b1, w);
            if (i < 2) begin
                b = rnd();
                i_host.cyc(offs[i] + 16'h0040 + 16'(i), 1'b1, i ? {b[7:0], ~b[7:0]} : {~b[7:0], b[7:0]});
                w = i ? {b[7:0], w[7:0]} : {w[15:8], b[7:0]};
            end
            rd(offs[i], w);
        end
        for (int i = 0; i < 2; i++) begin
            w = i ? 16'h000a : 16'h0005;
            i_host.cyc(16'h0300, 1'b1, w);
            @(negedge clk);
            chk({12'h000, rx_n, rx_oe, tx_n, tx_oe}, w);
            @(posedge clk);
            pend <= i[0];
            need <= i[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({irq_n, irq_oe, br_n, br_oe}, {1'b0, i[0], 1'b0, i[0]});
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            iack_n <= 1'b0;
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk(ans, 16'(i));
            @(posedge clk);
            iack_n <= 1'b1;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
